// ### conv_cfg_pkg.sv
// Package: register map, field layout and pattern encodings of the converter config slice
package conv_cfg_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADDR_IFACE_SEL    = 8'h07;
    localparam logic [7:0] ADDR_ANALOG_IN    = 8'h11;
    localparam logic [7:0] ADDR_FUSE_LOAD    = 8'h13;
    localparam logic [7:0] ADDR_PAT_LOW      = 8'h14;
    localparam logic [7:0] ADDR_PAT_MID      = 8'h15;
    localparam logic [7:0] ADDR_PAT_SEL      = 8'h16;
    localparam logic [7:0] ADDR_FRAME_CLK    = 8'h19;
    localparam logic [7:0] RESET_VALUE       = 8'h00;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_SINGLE_ENDED  = 5;
    localparam int BIT_DELAY_LOOP_POWERDOWN       = 2;
    localparam int BIT_AUTOZERO      = 0;
    localparam int BIT_FUSE_LOAD     = 0;
    localparam int BIT_FRAME_CLOCK_SOURCE      = 7;
    localparam int BIT_FRAME_CLOCK_DIVIDE      = 4;
    localparam int BIT_FRAME_CLOCK_STRETCH  = 0;
    localparam logic [7:0] MASK_ANALOG_IN = 8'h25;
    localparam logic [7:0] MASK_FUSE_LOAD = 8'h01;
    localparam logic [7:0] MASK_FRAME_CLK = 8'h91;
    localparam int PAT_WIDTH = 18;
    localparam int PAT_HIGH_BITS  = 2;
    localparam int PAT_SEL_A_LSB  = 2;
    localparam int PAT_SEL_B_LSB  = 5;
    localparam int PAT_CODE_WIDTH = 3;
    // ****************************************
    // Pattern select codes
    // ****************************************
    localparam logic [2:0] PAT_NORMAL   = 3'h0;
    localparam logic [2:0] PAT_RAMP     = 3'h2;
    localparam logic [2:0] PAT_CONSTANT = 3'h3;
    // Ramp increments per native resolution (host side)
    localparam logic [17:0] RAMP_STEP_16 = 18'h00004;
    localparam logic [17:0] RAMP_STEP_18 = 18'h00001;
    localparam logic [17:0] RAMP_STEP_14 = 18'h00010;
    // ****************************************
    // Host APB register map (32-bit words)
    // ****************************************
    localparam logic [7:0] APB_CMD    = 8'h00;
    localparam logic [7:0] APB_STATUS = 8'h04;
    localparam logic [7:0] APB_RDATA  = 8'h08;
    localparam int CMD_WRITE_BIT = 16;
    localparam int CMD_GO_BIT    = 31;
endpackage : conv_cfg_pkg

// ### conv_cfg_if.sv
// Interface: register port between host controller and converter config slice
interface conv_cfg_if;
    logic       wrStrobe;
    logic       rdStrobe;
    logic [7:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    logic       rdValid;
    modport device (input wrStrobe, rdStrobe, addr, wrData, output rdData, rdValid);
    modport host   (output wrStrobe, rdStrobe, addr, wrData, input rdData, rdValid);
endinterface : conv_cfg_if

// ### converter_config_test_pattern.sv
// Device end: config registers, fuse-map load and test-pattern generator

// Summary of operation
// - Channel A select: normal, ramp, constant
// - Channel B select uses same encoding
// - 18-bit user word across three registers
// - Host loads ramp step per resolution
// - Pattern inserted before mapper, MSB aligned
// - Mapping applied after load pulse high-low
// - Fuse load resets earlier register writes except interface select
// - Auto-zero polarity depends on variant
// - Delay-loop powerdown gives half-period sampling on fastest variant only
// - Bit 5 selects single-ended channel A
// - Host sets frame source only complex
module converter_config_test_pattern #(
    parameter bit FASTEST_VARIANT = 1'b0,
    parameter int NATIVE_BITS     = 16
) (
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    conv_cfg_if.device                  cfg,
    input  wire logic                   sampleEnable,
    input  wire logic [NATIVE_BITS-1:0] convDataA,
    input  wire logic [NATIVE_BITS-1:0] convDataB,
    output logic      [NATIVE_BITS-1:0] mapperInA,
    output logic      [NATIVE_BITS-1:0] mapperInB,
    output logic      [7:0]             appliedInterface,
    output logic                        singleEndedInA,
    output logic                        autozeroActive,
    output logic                        halfPeriodSampling,
    output logic                        frameClockSource,
    output logic                        frameClockDivide,
    output logic                        frameClockStretch
);
    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0]  ifaceSel;
    logic [7:0]  analogInput;
    logic [7:0]  fuseLoad;
    logic [7:0]  patLow;
    logic [7:0]  patMid;
    logic [7:0]  patSel;
    logic [7:0]  frameClk;
    logic        fuseFalling;
    logic [2:0]  patternSelectA;
    logic [2:0]  patternSelectB;
    logic [17:0] userPatternWord;

    // ****************************************
    // Fuse-map load sequencing
    // ****************************************
    // High-then-low of the load bit completes the load; that clearing write is not stored
    assign fuseFalling = cfg.wrStrobe && cfg.addr == conv_cfg_pkg::ADDR_FUSE_LOAD
                         && fuseLoad[conv_cfg_pkg::BIT_FUSE_LOAD]
                         && !cfg.wrData[conv_cfg_pkg::BIT_FUSE_LOAD];

    // Interface selection survives the load, so the mapping it names can be applied
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ifaceSel <= conv_cfg_pkg::RESET_VALUE;
        end else if (cfg.wrStrobe && cfg.addr == conv_cfg_pkg::ADDR_IFACE_SEL) begin
            ifaceSel <= cfg.wrData;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            analogInput <= conv_cfg_pkg::RESET_VALUE;
            fuseLoad    <= conv_cfg_pkg::RESET_VALUE;
            patLow      <= conv_cfg_pkg::RESET_VALUE;
            patMid      <= conv_cfg_pkg::RESET_VALUE;
            patSel      <= conv_cfg_pkg::RESET_VALUE;
            frameClk    <= conv_cfg_pkg::RESET_VALUE;
        end else if (fuseFalling) begin
            // Load wipes earlier writes except interface selection
            analogInput <= conv_cfg_pkg::RESET_VALUE;
            fuseLoad    <= conv_cfg_pkg::RESET_VALUE;
            patLow      <= conv_cfg_pkg::RESET_VALUE;
            patMid      <= conv_cfg_pkg::RESET_VALUE;
            patSel      <= conv_cfg_pkg::RESET_VALUE;
            frameClk    <= conv_cfg_pkg::RESET_VALUE;
        end else if (cfg.wrStrobe) begin
            case (cfg.addr)
                conv_cfg_pkg::ADDR_ANALOG_IN: analogInput <= cfg.wrData;
                conv_cfg_pkg::ADDR_FUSE_LOAD: fuseLoad    <= cfg.wrData;
                conv_cfg_pkg::ADDR_PAT_LOW:   patLow      <= cfg.wrData;
                conv_cfg_pkg::ADDR_PAT_MID:   patMid      <= cfg.wrData;
                conv_cfg_pkg::ADDR_PAT_SEL:   patSel      <= cfg.wrData;
                conv_cfg_pkg::ADDR_FRAME_CLK: frameClk    <= cfg.wrData;
                default: ;
            endcase
        end
    end

    // ****************************************
    // Interface mapping
    // ****************************************
    // Mapping changes only on a completed load, never on the selection write itself
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            appliedInterface <= conv_cfg_pkg::RESET_VALUE;
        end else if (fuseFalling) begin
            appliedInterface <= ifaceSel;
        end
    end

    // ****************************************
    // Register read-back
    // ****************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cfg.rdData  <= conv_cfg_pkg::RESET_VALUE;
            cfg.rdValid <= 1'b0;
        end else begin
            cfg.rdValid <= cfg.rdStrobe;
            if (cfg.rdStrobe) begin
                case (cfg.addr)
                    conv_cfg_pkg::ADDR_IFACE_SEL: cfg.rdData <= ifaceSel;
                    conv_cfg_pkg::ADDR_ANALOG_IN: cfg.rdData <= analogInput;
                    conv_cfg_pkg::ADDR_FUSE_LOAD: cfg.rdData <= fuseLoad;
                    conv_cfg_pkg::ADDR_PAT_LOW:   cfg.rdData <= patLow;
                    conv_cfg_pkg::ADDR_PAT_MID:   cfg.rdData <= patMid;
                    conv_cfg_pkg::ADDR_PAT_SEL:   cfg.rdData <= patSel;
                    conv_cfg_pkg::ADDR_FRAME_CLK: cfg.rdData <= frameClk;
                    // Unmapped addresses read as zero
                    default:                      cfg.rdData <= conv_cfg_pkg::RESET_VALUE;
                endcase
            end
        end
    end

    // ****************************************
    // Analog and frame-clock controls
    // ****************************************
    assign singleEndedInA = analogInput[conv_cfg_pkg::BIT_SINGLE_ENDED];
    assign autozeroActive = FASTEST_VARIANT ? analogInput[conv_cfg_pkg::BIT_AUTOZERO]
                                            : !analogInput[conv_cfg_pkg::BIT_AUTOZERO];
    // Delay-loop bit only acts on the fastest variant
    assign halfPeriodSampling = FASTEST_VARIANT
                                && analogInput[conv_cfg_pkg::BIT_DELAY_LOOP_POWERDOWN];
    assign frameClockSource  = frameClk[conv_cfg_pkg::BIT_FRAME_CLOCK_SOURCE];
    assign frameClockDivide  = frameClk[conv_cfg_pkg::BIT_FRAME_CLOCK_DIVIDE];
    assign frameClockStretch = frameClk[conv_cfg_pkg::BIT_FRAME_CLOCK_STRETCH];

    // ****************************************
    // Test-pattern generator
    // ****************************************
    assign userPatternWord = {patSel[conv_cfg_pkg::PAT_HIGH_BITS-1:0], patMid, patLow};
    assign patternSelectA  =
        patSel[conv_cfg_pkg::PAT_SEL_A_LSB +: conv_cfg_pkg::PAT_CODE_WIDTH];
    assign patternSelectB  =
        patSel[conv_cfg_pkg::PAT_SEL_B_LSB +: conv_cfg_pkg::PAT_CODE_WIDTH];

    // Native-width slice taken from the top of the user word
    logic [NATIVE_BITS-1:0] userNative;
    assign userNative = userPatternWord[conv_cfg_pkg::PAT_WIDTH-1 -: NATIVE_BITS];

    // Both lanes share one user word; each has its own select
    pattern_lane #(.WIDTH(NATIVE_BITS)) laneA (
        .clock        (clock),
        .reset_n      (reset_n),
        .sampleEnable (sampleEnable),
        .select       (patternSelectA),
        .userWord     (userNative),
        .convData     (convDataA),
        .laneOut      (mapperInA)
    );
    pattern_lane #(.WIDTH(NATIVE_BITS)) laneB (
        .clock        (clock),
        .reset_n      (reset_n),
        .sampleEnable (sampleEnable),
        .select       (patternSelectB),
        .userWord     (userNative),
        .convData     (convDataB),
        .laneOut      (mapperInB)
    );
endmodule : converter_config_test_pattern

// One channel of pattern insertion ahead of the bit mapper
module pattern_lane #(
    parameter int WIDTH = 16
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             sampleEnable,
    input  wire logic [2:0]       select,
    input  wire logic [WIDTH-1:0] userWord,
    input  wire logic [WIDTH-1:0] convData,
    output logic      [WIDTH-1:0] laneOut
);
    // ****************************************
    // Sample-rate update
    // ****************************************
    // Ramp continues from whatever the lane showed last; a mode change does not restart it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            laneOut <= '0;
        end else if (sampleEnable) begin
            case (select)
                conv_cfg_pkg::PAT_RAMP:     laneOut <= laneOut + userWord;
                conv_cfg_pkg::PAT_CONSTANT: laneOut <= userWord;
                default:                    laneOut <= convData;
            endcase
        end
    end
endmodule : pattern_lane

// ### converter_config_host.sv
// Host end: APB-programmed controller that drives the converter register port
module converter_config_host (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    conv_cfg_if.host         cfg
);
    // ****************************************
    // Command sequencer
    // ****************************************
    typedef enum {IDLE, ISSUE, WAIT_READ} state_e;
    state_e     state;
    logic       busy;
    logic [7:0] lastRead;
    logic       apbWrite;
    assign apbWrite = psel && penable && pwrite;
    assign pready   = 1'b1;
    assign busy     = state != IDLE;

    // Command word: [31] go, [16] write, [15:8] address, [7:0] data.
    // Reserved bits and ordering of fuse load are software's duty.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state        <= IDLE;
            cfg.wrStrobe <= 1'b0;
            cfg.rdStrobe <= 1'b0;
            cfg.addr     <= 8'h00;
            cfg.wrData   <= 8'h00;
            lastRead     <= 8'h00;
        end else begin
            cfg.wrStrobe <= 1'b0;
            cfg.rdStrobe <= 1'b0;
            case (state)
                IDLE: begin
                    if (apbWrite && paddr == conv_cfg_pkg::APB_CMD
                        && pwdata[conv_cfg_pkg::CMD_GO_BIT]) begin
                        cfg.addr   <= pwdata[15:8];
                        cfg.wrData <= pwdata[7:0];
                        if (pwdata[conv_cfg_pkg::CMD_WRITE_BIT]) begin
                            cfg.wrStrobe <= 1'b1;
                            state        <= ISSUE;
                        end else begin
                            cfg.rdStrobe <= 1'b1;
                            state        <= WAIT_READ;
                        end
                    end
                end
                ISSUE: state <= IDLE;
                WAIT_READ: begin
                    if (cfg.rdValid) begin
                        lastRead <= cfg.rdData;
                        state    <= IDLE;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end

    always_comb begin
        pslverr = 1'b0;
        case (paddr)
            conv_cfg_pkg::APB_STATUS: prdata = {31'h0, busy};
            conv_cfg_pkg::APB_RDATA:  prdata = {24'h0, lastRead};
            conv_cfg_pkg::APB_CMD:    prdata = {16'h0, cfg.addr, cfg.wrData};
            default: begin
                prdata  = 32'h0;
                pslverr = psel && penable;
            end
        endcase
    end
endmodule : converter_config_host

// ### conv_cfg_asserts.sv
// Checker: timing and readback assertions on the converter register port
module conv_cfg_asserts (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       wrStrobe,
    input wire logic       rdStrobe,
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic [7:0] rdData,
    input wire logic       rdValid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] shadowLow;
    logic [7:0] shadowSel;
    logic [7:0] shadowIface;
    logic       fuseSet;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Shadow copies; the clearing write of the load bit wipes all but the interface
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            {shadowLow, shadowSel, shadowIface, fuseSet} <= '0;
        end else if (wrStrobe) begin
            if (addr == conv_cfg_pkg::ADDR_FUSE_LOAD && fuseSet && !wrData[0]) begin
                {shadowLow, shadowSel, fuseSet} <= '0;
            end else begin
                if (addr == conv_cfg_pkg::ADDR_PAT_LOW) shadowLow <= wrData;
                if (addr == conv_cfg_pkg::ADDR_PAT_SEL) shadowSel <= wrData;
                if (addr == conv_cfg_pkg::ADDR_IFACE_SEL) shadowIface <= wrData;
                if (addr == conv_cfg_pkg::ADDR_FUSE_LOAD) fuseSet <= wrData[0];
            end
        end
    end
    a_read_answer_time: assert property (rdStrobe |=> rdValid)
        else $error("read answer missing");
    a_valid_has_cause: assert property (rdValid |-> $past(rdStrobe))
        else $error("read answer without request");
    a_strobes_apart: assert property (!(wrStrobe && rdStrobe))
        else $error("read and write together");
    a_write_single_pulse: assert property (wrStrobe |=> !wrStrobe)
        else $error("write strobe too long");
    a_low_word_back: assert property (rdStrobe && addr == conv_cfg_pkg::ADDR_PAT_LOW
        |=> rdData == $past(shadowLow)) else $error("low word readback wrong");
    a_select_back: assert property (rdStrobe && addr == conv_cfg_pkg::ADDR_PAT_SEL
        |=> rdData == $past(shadowSel)) else $error("select readback wrong");
    a_iface_kept: assert property (rdStrobe && addr == conv_cfg_pkg::ADDR_IFACE_SEL
        |=> rdData == $past(shadowIface)) else $error("interface value lost");
    a_analog_reserved_zero: assert property (wrStrobe && addr == conv_cfg_pkg::ADDR_ANALOG_IN
        |-> (wrData & ~conv_cfg_pkg::MASK_ANALOG_IN) == 8'h00) else $error("reserved set");
    a_unmapped_reads_zero: assert property (rdStrobe && addr == 8'h20 |=> rdData == 8'h00)
        else $error("unmapped read not zero");
    c_fuse_clear: cover property (wrStrobe && addr == conv_cfg_pkg::ADDR_FUSE_LOAD && fuseSet);
    c_low_read: cover property (rdStrobe && addr == conv_cfg_pkg::ADDR_PAT_LOW);
    c_iface_read: cover property (rdStrobe && addr == conv_cfg_pkg::ADDR_IFACE_SEL);
endmodule : conv_cfg_asserts

// ### tb.sv
// Testbench: APB-driven host programming the converter config slice
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sampleEnable = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, err;
    logic [15:0] convDataA = 16'h1234, convDataB = 16'hABCD, mapperInA, mapperInB;
    logic [7:0]  appliedInterface;
    logic        singleEndedInA, autozeroActive, halfPeriodSampling;
    logic        frameClockSource, frameClockDivide, frameClockStretch;
    int          n_errors = 0, total_checks = 0;
    conv_cfg_if bus ();
    always #20 clock = ~clock;
    converter_config_test_pattern converter_config_test_pattern_inst (.clock(clock),
        .reset_n(reset_n), .cfg(bus.device), .sampleEnable(sampleEnable),
        .convDataA(convDataA), .convDataB(convDataB), .mapperInA(mapperInA),
        .mapperInB(mapperInB), .appliedInterface(appliedInterface),
        .singleEndedInA(singleEndedInA), .autozeroActive(autozeroActive),
        .halfPeriodSampling(halfPeriodSampling), .frameClockSource(frameClockSource),
        .frameClockDivide(frameClockDivide), .frameClockStretch(frameClockStretch));
    converter_config_host converter_config_host_inst (.clock(clock), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(bus.host));
    conv_cfg_asserts conv_cfg_asserts_inst (.clock(clock), .reset_n(reset_n),
        .wrStrobe(bus.wrStrobe), .rdStrobe(bus.rdStrobe), .addr(bus.addr),
        .wrData(bus.wrData), .rdData(bus.rdData), .rdValid(bus.rdValid));
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task issue(input logic wr, input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, conv_cfg_pkg::APB_CMD, {1'b1, 14'h0, wr, a, d});
        do apb(1'b0, conv_cfg_pkg::APB_STATUS, 32'h0); while (q[0] !== 1'b0);
    endtask : issue
    task cfg_read(input logic [7:0] a, input logic [7:0] exp, input string name);
        issue(1'b0, a, 8'h00);
        apb(1'b0, conv_cfg_pkg::APB_RDATA, 32'h0);
        check(name, {24'h0, exp}, {24'h0, q[7:0]});
    endtask : cfg_read
    task step(input logic [15:0] expA, input logic [15:0] expB);
        @(posedge clock);
        sampleEnable <= 1'b1;
        @(posedge clock);
        sampleEnable <= 1'b0;
        #1;
        check("mapperInA", {16'h0, expA}, {16'h0, mapperInA});
        check("mapperInB", {16'h0, expB}, {16'h0, mapperInB});
    endtask : step
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        #80000;
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        #1 check("autozeroActive", 32'h1, {31'h0, autozeroActive});
        cfg_read(conv_cfg_pkg::ADDR_ANALOG_IN, 8'h00, "analog reset");
        apb(1'b0, 8'h0C, 32'h0);
        check("pslverr", 32'h1, {31'h0, err});
        $display("test reset done");
        issue(1'b1, conv_cfg_pkg::ADDR_IFACE_SEL, 8'h5A);
        issue(1'b1, conv_cfg_pkg::ADDR_PAT_LOW, 8'h33);
        issue(1'b1, conv_cfg_pkg::ADDR_FUSE_LOAD, 8'h01);
        issue(1'b1, conv_cfg_pkg::ADDR_FUSE_LOAD, 8'h00);
        check("appliedInterface", 32'h5A, {24'h0, appliedInterface});
        cfg_read(conv_cfg_pkg::ADDR_PAT_LOW, 8'h00, "low after load");
        cfg_read(conv_cfg_pkg::ADDR_IFACE_SEL, 8'h5A, "iface after load");
        $display("test fuse load done");
        issue(1'b1, conv_cfg_pkg::ADDR_ANALOG_IN, 8'h25);
        check("singleEndedInA", 32'h1, {31'h0, singleEndedInA});
        check("autozeroActive", 32'h0, {31'h0, autozeroActive});
        check("halfPeriod", 32'h0, {31'h0, halfPeriodSampling});
        issue(1'b1, conv_cfg_pkg::ADDR_FRAME_CLK, 8'h91);
        check("frameClock", 32'h7, {29'h0, frameClockSource, frameClockDivide, frameClockStretch});
        issue(1'b1, 8'h20, 8'hFF);
        cfg_read(8'h20, 8'h00, "unmapped");
        $display("test controls done");
        issue(1'b1, conv_cfg_pkg::ADDR_PAT_LOW, 8'h5A);
        issue(1'b1, conv_cfg_pkg::ADDR_PAT_MID, 8'hC3);
        issue(1'b1, conv_cfg_pkg::ADDR_PAT_SEL, 8'h6E);
        cfg_read(conv_cfg_pkg::ADDR_PAT_SEL, 8'h6E, "select back");
        step(16'hB0D6, 16'hB0D6);
        issue(1'b1, conv_cfg_pkg::ADDR_PAT_SEL, 8'h1C);
        step(16'h1234, 16'hABCD);
        issue(1'b1, conv_cfg_pkg::ADDR_PAT_LOW, 8'hFF);
        issue(1'b1, conv_cfg_pkg::ADDR_PAT_MID, 8'hFF);
        issue(1'b1, conv_cfg_pkg::ADDR_PAT_SEL, 8'h6F);
        step(16'hFFFF, 16'hFFFF);
        issue(1'b1, conv_cfg_pkg::ADDR_PAT_LOW, conv_cfg_pkg::RAMP_STEP_16[7:0]);
        issue(1'b1, conv_cfg_pkg::ADDR_PAT_MID, 8'h00);
        issue(1'b1, conv_cfg_pkg::ADDR_PAT_SEL, 8'h08);
        step(16'h0000, 16'hABCD);
        step(16'h0001, 16'hABCD);
        issue(1'b1, conv_cfg_pkg::ADDR_PAT_SEL, 8'h48);
        step(16'h0002, 16'hABCE);
        $display("test patterns done");
        print_verdict();
    end
endmodule : tb
